//--- mdv_issuer.sv
// Purpose: Issuing pipeline model in front of the unit
// Assumes: Commands arrive on go_i at a falling edge
// Notes: Released request shows inverted values
`timescale 1ns/10ps
module mdv_issuer (
   input wire logic ref_clk_i,
   input wire logic stall_i,
   input wire logic go_i,
   input wire mdv_pkg::mdv_req_t cmd_i,
   output mdv_pkg::mdv_req_t req_o,
   output logic taken_o
);
   initial begin
      req_o = '0;
      taken_o = 1'b0;
   end
   // Held until an edge with no stall
   always @(posedge ref_clk_i) taken_o <= req_o.valid && !stall_i;
   always @(negedge ref_clk_i) begin
      if (go_i) begin
         req_o <= cmd_i;
      end else if (taken_o) begin
         req_o <= mdv_pkg::mdv_req_t'(~req_o);
      end
   end
endmodule : mdv_issuer

//--- mdv_pkg.sv
// Purpose: Constants and types for the multiply/divide unit
// Assumes: 32-bit operands, one core clock, issue from the integer pipeline
// Notes: Latency figures count clock edges after the issue edge
// Notes on behaviour
// - Own pipeline keeps running while issuer stalls
// - Booth-recoded array, 32-bit by 16-bit slice
// - Pass count set by second operand only
// - Short operand one pass, full width two
// - Short multiply each cycle, wide every second
// - Back-to-back wide multiplies are stalled
// - Operand size found from values, not instruction
// - Divider yields one quotient bit per clock
// - Dividend sign extension skips 23, 15, 7 iterations
// - Issue stalls until the last two cycles of a divide
// - Results kept in high and low registers
// - Pair multiplies: latency/repeat 1/1 or 2/2
// - Register multiply: latency/repeat 2/1 or 3/2
// - Divide latency 12/19/26/33, repeat 11/18/25/32
package mdv_pkg;

   typedef enum logic [2:0] {
      MDV_OP_MULT = 3'h0,
      MDV_OP_MADD = 3'h1,
      MDV_OP_MSUB = 3'h2,
      MDV_OP_MUL_GPR = 3'h3,
      MDV_OP_DIV = 3'h4
   } mdv_op_t;

   typedef struct packed {
      logic valid;
      mdv_op_t op;
      logic is_signed;
      logic [31:0] first_source_operand;
      logic [31:0] second_source_operand;
   } mdv_req_t;

   typedef enum logic [0:0] {
      MDV_DIV_IDLE = 1'b0,
      MDV_DIV_RUN = 1'b1
   } mdv_div_state_t;

   localparam logic [5:0] MDV_DIV_BITS = 6'h20;
   localparam logic [5:0] MDV_SKIP_8 = 6'h17;
   localparam logic [5:0] MDV_SKIP_16 = 6'h0f;
   localparam logic [5:0] MDV_SKIP_24 = 6'h07;
   localparam logic [5:0] MDV_SKIP_32 = 6'h00;
   localparam logic [5:0] MDV_DIV_LAT_8 = 6'h0c;
   localparam logic [5:0] MDV_DIV_LAT_16 = 6'h13;
   localparam logic [5:0] MDV_DIV_LAT_24 = 6'h1a;
   localparam logic [5:0] MDV_DIV_LAT_32 = 6'h21;
   localparam logic [5:0] MDV_DIV_RELEASE = 6'h02;
   localparam logic [5:0] MDV_DIV_LAST = 6'h01;
   localparam logic [4:0] MDV_PASS2_SHIFT = 5'h10;

endpackage : mdv_pkg

//--- mdv_unit.sv
// Purpose: Multiply/divide unit beside the integer pipeline
// Assumes: Requests are taken only while stall_o is low
// Notes: One shared 32x16 array; serial restoring divider
`timescale 1ns/10ps

module mdv_unit (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire mdv_pkg::mdv_req_t req_i,
   output logic stall_o,
   output logic div_busy_o,
   output logic [31:0] result_high_o,
   output logic [31:0] result_low_o,
   output logic [31:0] gpr_result_o,
   output logic gpr_valid_o
);

   // Radix-4 Booth pass of a 33-bit signed by 17-bit signed slice
   function automatic logic signed [49:0] booth_pass(
      input logic signed [32:0] a,
      input logic [16:0] b
   );
      logic signed [49:0] acc;
      logic signed [49:0] ae;
      logic signed [49:0] pp;
      logic [18:0] bx;
      logic [2:0] dig;
      acc = '0;
      ae = {{17{a[32]}}, a};
      bx = {b[16], b, 1'b0};
      for (int i = 0; i < 9; i++) begin
         dig = bx[2*i +: 3];
         case (dig)
            3'h1, 3'h2: pp = ae;
            3'h3: pp = ae <<< 1;
            3'h4: pp = -(ae <<< 1);
            3'h5, 3'h6: pp = -ae;
            default: pp = '0;
         endcase
         acc = acc + (pp <<< (2 * i));
      end
      return acc;
   endfunction : booth_pass

   // Width class of a dividend from its sign extension
   function automatic logic [1:0] width_class(
      input logic [31:0] v,
      input logic sgn
   );
      logic ext;
      logic [2:0] lead;
      ext = sgn & v[31];
      // A signed value keeps its top bit as sign; unsigned uses all bits
      lead = sgn ? {v[23], v[15], v[7]} : 3'h0;
      if ((v[31:8] == {24{ext}}) && (lead[0] == ext)) begin
         return 2'h0;
      end else if ((v[31:16] == {16{ext}}) && (lead[1] == ext)) begin
         return 2'h1;
      end else if ((v[31:24] == {8{ext}}) && (lead[2] == ext)) begin
         return 2'h2;
      end
      return 2'h3;
   endfunction : width_class

   // Request decode
   wire logic is_mul_op;
   wire logic is_div_op;
   wire logic take;
   wire logic take_mul;
   wire logic take_div;
   wire logic b_short;
   wire logic take_short;
   wire logic take_wide;
   wire logic [31:0] opa;
   wire logic [31:0] opb;

   assign opa = req_i.first_source_operand;
   assign opb = req_i.second_source_operand;
   assign is_div_op = req_i.op == mdv_pkg::MDV_OP_DIV;
   assign is_mul_op = (req_i.op == mdv_pkg::MDV_OP_MULT) ||
                      (req_i.op == mdv_pkg::MDV_OP_MADD) ||
                      (req_i.op == mdv_pkg::MDV_OP_MSUB) ||
                      (req_i.op == mdv_pkg::MDV_OP_MUL_GPR);
   assign take = req_i.valid & ~stall_o;
   assign take_mul = take & is_mul_op;
   assign take_div = take & is_div_op;
   // Size taken from the second operand value alone
   assign b_short = req_i.is_signed ?
      ((&opb[31:15]) | ~(|opb[31:15])) : ~(|opb[31:16]);
   assign take_short = take_mul & b_short;
   assign take_wide = take_mul & ~b_short;

   // Multiplier state
   logic wide_ff;
   logic signed [32:0] wa_ff;
   logic [16:0] wbhi_ff;
   mdv_pkg::mdv_op_t wop_ff;
   logic [63:0] p1_ff;
   logic fin_vld_ff;
   mdv_pkg::mdv_op_t fin_op_ff;
   logic [63:0] fin_prod_ff;
   logic [63:0] hilo_ff;
   logic [31:0] gmid_ff;
   logic gmid_vld_ff;
   logic [31:0] gpr_result_ff;
   logic gpr_valid_ff;
   logic stall_ff;

   // Shared array: pass 2 of a wide multiply owns it for one cycle
   wire logic signed [32:0] arr_a;
   wire logic [16:0] arr_b;
   wire logic signed [49:0] arr_p;
   wire logic [63:0] arr_p64;
   wire logic signed [32:0] req_a33;

   assign req_a33 = {req_i.is_signed & opa[31], opa};
   assign arr_a = wide_ff ? wa_ff : req_a33;
   assign arr_b = wide_ff ? wbhi_ff :
      (b_short ? {req_i.is_signed & opb[15], opb[15:0]} :
                 {1'b0, opb[15:0]});
   assign arr_p = booth_pass(arr_a, arr_b);
   assign arr_p64 = {{14{arr_p[49]}}, arr_p};

   wire logic [63:0] wide_prod;
   assign wide_prod = p1_ff + (arr_p64 << mdv_pkg::MDV_PASS2_SHIFT);

   // Divider state
   mdv_pkg::mdv_div_state_t div_state_ff;
   mdv_pkg::mdv_div_state_t nxt_div_state;
   logic [5:0] cnt_ff;
   logic [5:0] nxt_cnt;
   logic [5:0] iter_ff;
   logic [32:0] rem_ff;
   logic [31:0] quo_ff;
   logic [31:0] dvs_ff;
   logic negq_ff;
   logic negr_ff;

   wire logic [1:0] dcls;
   wire logic [5:0] dskip;
   wire logic [5:0] dlat;
   wire logic [31:0] dmag;
   wire logic [31:0] vmag;
   wire logic div_run;
   wire logic div_done;
   wire logic [32:0] shifted;
   wire logic [32:0] diff;
   wire logic [31:0] div_hi;
   wire logic [31:0] div_lo;
   wire logic [63:0] base;

   assign dcls = width_class(opa, req_i.is_signed);
   // Early-in skip from dividend sign extension
   assign dskip = (dcls == 2'h0) ? mdv_pkg::MDV_SKIP_8 :
                  (dcls == 2'h1) ? mdv_pkg::MDV_SKIP_16 :
                  (dcls == 2'h2) ? mdv_pkg::MDV_SKIP_24 :
                  mdv_pkg::MDV_SKIP_32;
   assign dlat = (dcls == 2'h0) ? mdv_pkg::MDV_DIV_LAT_8 :
                 (dcls == 2'h1) ? mdv_pkg::MDV_DIV_LAT_16 :
                 (dcls == 2'h2) ? mdv_pkg::MDV_DIV_LAT_24 :
                 mdv_pkg::MDV_DIV_LAT_32;
   assign dmag = (req_i.is_signed & opa[31]) ? -opa : opa;
   assign vmag = (req_i.is_signed & opb[31]) ? -opb : opb;
   assign div_run = div_state_ff == mdv_pkg::MDV_DIV_RUN;
   assign div_done = div_run & (cnt_ff == mdv_pkg::MDV_DIV_LAST);
   assign shifted = {rem_ff[31:0], quo_ff[31]};
   assign diff = shifted - {1'b0, dvs_ff};
   assign div_hi = negr_ff ? -rem_ff[31:0] : rem_ff[31:0];
   assign div_lo = negq_ff ? -quo_ff : quo_ff;
   // A divide finishing this edge feeds a coincident accumulate
   assign base = div_done ? {div_hi, div_lo} : hilo_ff;

   assign nxt_div_state = take_div ? mdv_pkg::MDV_DIV_RUN :
      (div_done ? mdv_pkg::MDV_DIV_IDLE : div_state_ff);
   assign nxt_cnt = take_div ? dlat :
      (div_run ? 6'(cnt_ff - 6'h01) : 6'h00);

   // Array pass registers
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wide_ff <= 1'b0;
         wa_ff <= '0;
         wbhi_ff <= '0;
         wop_ff <= mdv_pkg::MDV_OP_MULT;
         p1_ff <= '0;
      end else begin
         wide_ff <= take_wide;
         if (take_wide) begin
            wa_ff <= req_a33;
            wbhi_ff <= {req_i.is_signed & opb[31], opb[31:16]};
            wop_ff <= req_i.op;
            p1_ff <= arr_p64;
         end
      end
   end

   // Final product stage
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         fin_vld_ff <= 1'b0;
         fin_op_ff <= mdv_pkg::MDV_OP_MULT;
         fin_prod_ff <= '0;
      end else begin
         fin_vld_ff <= take_short | wide_ff;
         if (wide_ff) begin
            fin_op_ff <= wop_ff;
            fin_prod_ff <= wide_prod;
         end else if (take_short) begin
            fin_op_ff <= req_i.op;
            fin_prod_ff <= arr_p64;
         end
      end
   end

   // Result pair and register-write path
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hilo_ff <= '0;
         gmid_ff <= '0;
         gmid_vld_ff <= 1'b0;
      end else begin
         gmid_vld_ff <= fin_vld_ff &
            (fin_op_ff == mdv_pkg::MDV_OP_MUL_GPR);
         if (fin_vld_ff) begin
            case (fin_op_ff)
               mdv_pkg::MDV_OP_MULT: hilo_ff <= fin_prod_ff;
               mdv_pkg::MDV_OP_MADD: hilo_ff <= base + fin_prod_ff;
               mdv_pkg::MDV_OP_MSUB: hilo_ff <= base - fin_prod_ff;
               mdv_pkg::MDV_OP_MUL_GPR: begin
                  gmid_ff <= fin_prod_ff[31:0];
                  hilo_ff <= base;
               end
               default: hilo_ff <= base;
            endcase
         end else if (div_done) begin
            hilo_ff <= {div_hi, div_lo};
         end
      end
   end

   // Output registers
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         gpr_result_ff <= '0;
         gpr_valid_ff <= 1'b0;
         stall_ff <= 1'b0;
      end else begin
         gpr_valid_ff <= gmid_vld_ff;
         if (gmid_vld_ff) begin
            gpr_result_ff <= gmid_ff;
         end
         stall_ff <= take_wide |
            (nxt_cnt > mdv_pkg::MDV_DIV_RELEASE);
      end
   end

   // Divide control
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_state_ff <= mdv_pkg::MDV_DIV_IDLE;
         cnt_ff <= '0;
      end else begin
         div_state_ff <= nxt_div_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // Divide datapath, one quotient bit per clock
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         iter_ff <= '0;
         rem_ff <= '0;
         quo_ff <= '0;
         dvs_ff <= '0;
         negq_ff <= 1'b0;
         negr_ff <= 1'b0;
      end else if (take_div) begin
         iter_ff <= 6'(mdv_pkg::MDV_DIV_BITS - dskip);
         rem_ff <= '0;
         quo_ff <= dmag << dskip;
         dvs_ff <= vmag;
         negq_ff <= req_i.is_signed & (opa[31] ^ opb[31]);
         negr_ff <= req_i.is_signed & opa[31];
      end else if (div_run && (iter_ff != 6'h00)) begin
         iter_ff <= 6'(iter_ff - 6'h01);
         if (!diff[32]) begin
            rem_ff <= diff;
            quo_ff <= {quo_ff[30:0], 1'b1};
         end else begin
            rem_ff <= shifted;
            quo_ff <= {quo_ff[30:0], 1'b0};
         end
      end
   end

   assign stall_o = stall_ff;
   assign div_busy_o = div_state_ff;
   assign result_high_o = hilo_ff[63:32];
   assign result_low_o = hilo_ff[31:0];
   assign gpr_result_o = gpr_result_ff;
   assign gpr_valid_o = gpr_valid_ff;

endmodule : mdv_unit

//--- mdv_unit_properties.sv
// Purpose: Port timing checks for the multiply/divide unit
// Assumes: Ports as mdv_unit declares them
// Notes: Bound to mdv_unit below
`timescale 1ns/10ps
module mdv_unit_props (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire mdv_pkg::mdv_req_t req_i,
   input wire logic stall_o,
   input wire logic div_busy_o,
   input wire logic [31:0] result_high_o,
   input wire logic [31:0] result_low_o,
   input wire logic [31:0] gpr_result_o,
   input wire logic gpr_valid_o
);
   wire logic [31:0] a = req_i.first_source_operand;
   wire logic [31:0] b = req_i.second_source_operand;
   wire logic sg = req_i.is_signed;
   wire logic take = req_i.valid && !stall_o;
   wire logic wd = sg ? !(&b[31:15] || ~|b[31:15]) : |b[31:16];
   wire logic a8 = sg ? (&a[31:7] || ~|a[31:7]) : ~|a[31:8];
   wire logic a32 = sg ? !(&a[31:23] || ~|a[31:23]) : |a[31:24];
   wire logic mul = req_i.op <= mdv_pkg::MDV_OP_MUL_GPR;
   wire logic div = req_i.op == mdv_pkg::MDV_OP_DIV;
   wire logic gpr = req_i.op == mdv_pkg::MDV_OP_MUL_GPR;
   wire logic mlt = req_i.op == mdv_pkg::MDV_OP_MULT;
   wire logic signed [63:0] ps = $signed(a) * $signed(b);
   wire logic [63:0] pu = {32'h0000_0000, a} * {32'h0000_0000, b};
   wire logic [63:0] prod = sg ? ps : pu;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   wide_stall_a: assert property (
      take && mul && wd |=> stall_o ##1 !stall_o)
      else $error("wide multiply stall wrong");
   short_go_a: assert property (
      take && mul && !wd |=> !stall_o)
      else $error("short multiply stalled");
   div_hold_a: assert property (
      take && div |=> stall_o && div_busy_o)
      else $error("divide not holding issue");
   div_short_a: assert property (
      take && div && a8 |-> ##10 stall_o ##1 !stall_o ##1 div_busy_o)
      else $error("8-bit divide timing wrong");
   div_full_a: assert property (
      take && div && a32 |-> ##31 stall_o ##1 !stall_o ##1 div_busy_o)
      else $error("32-bit divide timing wrong");
   gpr_short_a: assert property (
      take && gpr && !wd |-> ##3 gpr_valid_o)
      else $error("short register multiply late");
   gpr_wide_a: assert property (
      take && gpr && wd |-> ##3 !gpr_valid_o ##1 gpr_valid_o)
      else $error("wide register multiply timing wrong");
   pair_mult_a: assert property (
      take && mlt && !wd |-> ##2
         {result_high_o, result_low_o} == $past(prod, 2))
      else $error("short multiply result wrong");
endmodule : mdv_unit_props
bind mdv_unit mdv_unit_props u_props (.ref_clk_i(ref_clk_i),
   .nrst_i(nrst_i), .req_i(req_i), .stall_o(stall_o),
   .div_busy_o(div_busy_o), .result_high_o(result_high_o),
   .result_low_o(result_low_o), .gpr_result_o(gpr_result_o),
   .gpr_valid_o(gpr_valid_o));

//--- multiply_divide_unit_test.sv
// Purpose: Self-checking bench for the multiply/divide unit
// Assumes: Issuer model drives requests at falling edges
// Notes: Expected pair kept as a 64-bit model
`timescale 1ns/10ps
module multiply_divide_unit_test;
   logic ref_clk_i, nrst_i, go, stall, busy, gvalid, taken;
   mdv_pkg::mdv_req_t cmd, req;
   logic [31:0] hi, lo, gres;
   logic [63:0] pair, prod;
   int miscompares = 0, check_count = 0, seed = 32'h66bb_839c;
   mdv_unit DUT (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .req_i(req),
      .stall_o(stall), .div_busy_o(busy), .result_high_o(hi),
      .result_low_o(lo), .gpr_result_o(gres), .gpr_valid_o(gvalid));
   mdv_issuer u_iss (.ref_clk_i(ref_clk_i), .stall_i(stall), .go_i(go),
      .cmd_i(cmd), .req_o(req), .taken_o(taken));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   function automatic logic fits(logic [31:0] a, logic s, int w);
      logic [31:0] t;
      t = a >> w;
      if (s) t = $signed(a) >>> (w - 1);
      return t == 32'h0000_0000 || (s && t == 32'hffff_ffff);
   endfunction : fits
   task automatic run(input int i);
      logic [31:0] a, b, r;
      logic [63:0] old;
      logic s, w, dv;
      int lat, n;
      mdv_pkg::mdv_op_t op;
      op = mdv_pkg::mdv_op_t'(i % 5);
      dv = op == mdv_pkg::MDV_OP_DIV;
      s = 1'($random(seed));
      r = $random(seed);
      a = r >> ((i % 4) * 8);
      if (s) a = $signed(r) >>> ((i % 4) * 8);
      r = $random(seed);
      b = i[0] ? r >> 17 : r;
      if (dv) b = b | 32'h0000_0001;
      w = s ? !(&b[31:15] || ~|b[31:15]) : |b[31:16];
      prod = {32'h0000_0000, a} * {32'h0000_0000, b};
      if (s) prod = $signed(a) * $signed(b);
      old = pair;
      case (op)
         mdv_pkg::MDV_OP_MULT: pair = prod;
         mdv_pkg::MDV_OP_MADD: pair = pair + prod;
         mdv_pkg::MDV_OP_MSUB: pair = pair - prod;
         mdv_pkg::MDV_OP_MUL_GPR: pair = pair;
         default: pair = s ? {$signed(a) % $signed(b), $signed(a) / $signed(b)}
            : {a % b, a / b};
      endcase
      lat = (w ? 2 : 1) + (op == mdv_pkg::MDV_OP_MUL_GPR);
      if (dv) lat = 33;
      for (n = 3; dv && n >= 1; n--) if (fits(a, s, n * 8)) lat = 5 + n * 7;
      @(negedge ref_clk_i);
      cmd <= '{1'b1, op, s, a, b};
      go <= 1'b1;
      @(negedge ref_clk_i);
      go <= 1'b0;
      for (n = 0; taken !== 1'b1; n++) begin
         @(posedge ref_clk_i);
         #1;
         if (n == 50) begin
            miscompares++;
            give_verdict();
         end
      end
      chk(stall, w || dv);
      chk({hi, lo}, old);
      for (n = 1; n <= lat; n++) begin
         @(posedge ref_clk_i);
         #1;
         if (n == 1 && !dv) chk(stall, 0);
         if (n == lat - 1) begin
            chk({hi, lo}, old);
            chk(gvalid, 0);
         end
         if (dv && n >= lat - 3 && n <= lat - 2) begin
            chk(stall, n == lat - 3);
         end
      end
      chk({hi, lo}, pair);
      chk(busy, 0);
      if (op == mdv_pkg::MDV_OP_MUL_GPR) begin
         chk({gvalid, gres}, {1'b1, prod[31:0]});
      end
      $display("test %0d op %0d latency %0d done", i, op, lat);
   endtask : run
   initial begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      nrst_i = 1'b0;
      go = 1'b0;
      cmd = '0;
      pair = '0;
      repeat (10) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      nrst_i = 1'b1;
      chk({hi, lo}, 0);
      chk({gres, stall, busy, gvalid}, 0);
      for (int i = 0; i < 40; i++) run(i);
      give_verdict();
   end
endmodule : multiply_divide_unit_test
